/* File: src/sss_semaphore_events.sv */
// Purpose: Buffer ownership semaphore, events and interrupt enables
// Assumes: Engine strobes are synchronous one-cycle pulses or levels on CLK
// Notes: Processor owns the buffer after reset
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sss_consts.svh"

// How it works
// - Receive-buffer-full flag sets when the buffer fills under engine ownership.
// - Ownership-granted flag sets whenever the processor is handed the semaphore.
// - Shortcut bit set makes every transaction-done also trigger acquire.
// - Writing 1 to enable-set turns that event interrupt on; 0 does nothing.
// - Writing 1 to enable-clear turns it off; both read the same enables.
// - Status reads 0 free, 1 processor, 2 engine.
// - Status 3 while engine owns with processor acquire queued; handover at done.
// - Acquire task requests ownership for processor; release frees it for engine.
// - Transaction-done event raised when an engine-granted transaction completes.
module sss_semaphore_events (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Engine side
    input wire logic ENG_ACQ_REQ,
    input wire logic ENG_DONE,
    input wire logic ENG_RX_FULL,
    output logic ENG_OWNS,
    output logic CPU_OWNS,
    // Interrupt
    output logic IRQ
);

    sss_pkg::sss_core_s q;
    sss_pkg::sss_core_s d;
    sss_pkg::sss_bus_req_s req;
    logic [31:0] rdata;
    logic hit;
    logic acq_task;
    logic rel_task;
    logic acq_any;
    logic done_ev;
    logic rx_ev;
    logic grant_ev;
    logic eng_side;
    logic [2:0] ev_vec;

    // ----------------------------------------------------------------
    // Bus port
    // ----------------------------------------------------------------
    sss_apb_port u_port (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .paddr(PADDR),
        .pwdata(PWDATA),
        .prdata(PRDATA),
        .pready(PREADY),
        .pslverr(PSLVERR),
        .rdata(rdata),
        .hit(hit),
        .req(req)
    );

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always_comb begin
        rdata = `SSS_RST_RDATA;
        hit = 1'b1;
        unique case (PADDR)
            `SSS_OFS_ACQUIRE: begin
                rdata = `SSS_RST_RDATA;
            end
            `SSS_OFS_RELEASE: begin
                rdata = `SSS_RST_RDATA;
            end
            `SSS_OFS_EV_DONE: begin
                rdata[`SSS_BIT_EVENT] = q.ev_done;
            end
            `SSS_OFS_EV_RXFULL: begin
                rdata[`SSS_BIT_EVENT] = q.ev_rxfull;
            end
            `SSS_OFS_EV_GRANTED: begin
                rdata[`SSS_BIT_EVENT] = q.ev_granted;
            end
            `SSS_OFS_SHORTCUT: begin
                rdata[`SSS_BIT_SHORT_DONE_ACQ] = q.short_done_acq;
            end
            `SSS_OFS_IRQ_SET: begin
                rdata[2:0] = q.irq_en;
            end
            `SSS_OFS_IRQ_CLR: begin
                rdata[2:0] = q.irq_en;
            end
            `SSS_OFS_IRQ_PEND: begin
                rdata[2:0] = q.irq_pend;
            end
            `SSS_OFS_SEM_STATUS: begin
                rdata[1:0] = q.owner;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Tasks and engine events
    // ----------------------------------------------------------------
    always_comb begin
        acq_task = req.wr && (req.addr == `SSS_OFS_ACQUIRE)
            && req.wdata[`SSS_BIT_TASK];
        rel_task = req.wr && (req.addr == `SSS_OFS_RELEASE)
            && req.wdata[`SSS_BIT_TASK];
        eng_side = (q.owner == sss_pkg::SSS_ENGINE)
            || (q.owner == sss_pkg::SSS_ENGINE_PENDING);
        done_ev = ENG_DONE & eng_side;
        rx_ev = ENG_RX_FULL & eng_side;
        acq_any = acq_task | (done_ev & q.short_done_acq);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        grant_ev = 1'b0;

        // Semaphore owner
        unique case (q.owner)
            sss_pkg::SSS_FREE: begin
                if (acq_any) begin
                    d.owner = sss_pkg::SSS_CPU;
                    grant_ev = 1'b1;
                end else if (ENG_ACQ_REQ) begin
                    d.owner = sss_pkg::SSS_ENGINE;
                end
            end
            sss_pkg::SSS_CPU: begin
                if (rel_task) begin
                    d.owner = sss_pkg::SSS_FREE;
                end
            end
            sss_pkg::SSS_ENGINE: begin
                if (done_ev && acq_any) begin
                    d.owner = sss_pkg::SSS_CPU;
                    grant_ev = 1'b1;
                end else if (done_ev) begin
                    d.owner = sss_pkg::SSS_FREE;
                end else if (acq_any) begin
                    d.owner = sss_pkg::SSS_ENGINE_PENDING;
                end
            end
            sss_pkg::SSS_ENGINE_PENDING: begin
                if (done_ev) begin
                    d.owner = sss_pkg::SSS_CPU;
                    grant_ev = 1'b1;
                end else if (rel_task) begin
                    d.owner = sss_pkg::SSS_ENGINE;
                end
            end
        endcase

        // Event flags: software write first, hardware set wins
        if (req.wr && (req.addr == `SSS_OFS_EV_DONE)) begin
            d.ev_done = req.wdata[`SSS_BIT_EVENT];
        end
        if (req.wr && (req.addr == `SSS_OFS_EV_RXFULL)) begin
            d.ev_rxfull = req.wdata[`SSS_BIT_EVENT];
        end
        if (req.wr && (req.addr == `SSS_OFS_EV_GRANTED)) begin
            d.ev_granted = req.wdata[`SSS_BIT_EVENT];
        end
        if (done_ev) begin
            d.ev_done = 1'b1;
        end
        if (rx_ev) begin
            d.ev_rxfull = 1'b1;
        end
        if (grant_ev) begin
            d.ev_granted = 1'b1;
        end

        // Shortcut
        if (req.wr && (req.addr == `SSS_OFS_SHORTCUT)) begin
            d.short_done_acq = req.wdata[`SSS_BIT_SHORT_DONE_ACQ];
        end

        // Interrupt enables
        if (req.wr && (req.addr == `SSS_OFS_IRQ_SET)) begin
            d.irq_en = q.irq_en | req.wdata[2:0];
        end
        if (req.wr && (req.addr == `SSS_OFS_IRQ_CLR)) begin
            d.irq_en = q.irq_en & ~req.wdata[2:0];
        end

        // Pending interrupt status, cleared by read, set wins
        ev_vec = 3'h0;
        ev_vec[`SSS_BIT_EV_DONE] = done_ev;
        ev_vec[`SSS_BIT_EV_RXFULL] = rx_ev;
        ev_vec[`SSS_BIT_EV_GRANTED] = grant_ev;
        // Clear only the bits the read returned; later events survive
        if (req.rd && (req.addr == `SSS_OFS_IRQ_PEND)) begin
            d.irq_pend = q.irq_pend & ~PRDATA[2:0];
        end
        d.irq_pend = d.irq_pend | ev_vec;
        d.irq = |(d.irq_pend & d.irq_en);

        // Ownership outputs; status has no write path
        d.eng_owns = (d.owner == sss_pkg::SSS_ENGINE)
            || (d.owner == sss_pkg::SSS_ENGINE_PENDING);
        d.cpu_owns = (d.owner == sss_pkg::SSS_CPU);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            q.owner <= sss_pkg::SSS_CPU;
            q.ev_done <= `SSS_RST_EVENT;
            q.ev_rxfull <= `SSS_RST_EVENT;
            q.ev_granted <= `SSS_RST_EVENT;
            q.short_done_acq <= `SSS_RST_SHORTCUT;
            q.irq_en <= `SSS_RST_IRQ_EN;
            q.irq_pend <= `SSS_RST_IRQ_PEND;
            q.irq <= 1'b0;
            q.eng_owns <= 1'b0;
            q.cpu_owns <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign ENG_OWNS = q.eng_owns;
    assign CPU_OWNS = q.cpu_owns;
    assign IRQ = q.irq;

endmodule
`default_nettype wire

/* File: src/sss_consts.svh */
// Purpose: Offsets, field positions and reset values of the semaphore block
// Assumes: 12-bit APB byte address, 32-bit data
// Notes: Included by the design, checker and bench files
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSS_OFS_ACQUIRE 12'h024
`define SSS_OFS_RELEASE 12'h028
`define SSS_OFS_EV_DONE 12'h104
`define SSS_OFS_EV_RXFULL 12'h110
`define SSS_OFS_EV_GRANTED 12'h128
`define SSS_OFS_SHORTCUT 12'h200
`define SSS_OFS_IRQ_SET 12'h304
`define SSS_OFS_IRQ_CLR 12'h308
`define SSS_OFS_IRQ_PEND 12'h30C
`define SSS_OFS_SEM_STATUS 12'h400

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSS_BIT_EV_DONE 0
`define SSS_BIT_EV_RXFULL 1
`define SSS_BIT_EV_GRANTED 2
`define SSS_BIT_TASK 0
`define SSS_BIT_EVENT 0
`define SSS_BIT_SHORT_DONE_ACQ 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSS_RST_EVENT 1'h0
`define SSS_RST_SHORTCUT 1'h0
`define SSS_RST_IRQ_EN 3'h0
`define SSS_RST_IRQ_PEND 3'h0
`define SSS_RST_RDATA 32'h00000000

`endif

/* File: src/sss_pkg.sv */
// Purpose: Types shared by the semaphore block and its bus port
// Assumes: Constants live in sss_consts.svh
// Notes: Enum order gives the status codes 0..3
package sss_pkg;

    // ----------------------------------------------------------------
    // Semaphore owner
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SSS_FREE,
        SSS_CPU,
        SSS_ENGINE,
        SSS_ENGINE_PENDING
    } sss_owner_e;

    // ----------------------------------------------------------------
    // Completed bus access, one cycle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } sss_bus_req_s;

    // ----------------------------------------------------------------
    // Bus port state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ready;
        logic err;
        logic [31:0] rdata;
    } sss_port_s;

    // ----------------------------------------------------------------
    // Core state
    // ----------------------------------------------------------------
    typedef struct packed {
        sss_owner_e owner;
        logic ev_done;
        logic ev_rxfull;
        logic ev_granted;
        logic short_done_acq;
        logic [2:0] irq_en;
        logic [2:0] irq_pend;
        logic irq;
        logic eng_owns;
        logic cpu_owns;
    } sss_core_s;

endpackage

/* File: src/sss_apb_port.sv */
// Purpose: APB slave front end, one wait state per access
// Assumes: Caller decodes the address and supplies read data and a hit flag
// Notes: Access completes on the second access-phase cycle
`timescale 1ns/1ps
`default_nettype none
`include "sss_consts.svh"

module sss_apb_port (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoded access
    input wire logic [31:0] rdata,
    input wire logic hit,
    output sss_pkg::sss_bus_req_s req
);

    sss_pkg::sss_port_s q;
    sss_pkg::sss_port_s d;
    logic access;

    // ----------------------------------------------------------------
    // Handshake
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        access = psel & penable;
        d.ready = access & ~q.ready;
        // Error stands only with the ready pulse
        d.err = access & ~q.ready & ~hit;
        if (access && !q.ready) begin
            d.rdata = (pwrite || !hit) ? `SSS_RST_RDATA : rdata;
        end
        req.wr = access & q.ready & pwrite & hit;
        req.rd = access & q.ready & ~pwrite & hit;
        req.addr = paddr;
        req.wdata = pwdata;
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.err;

endmodule
`default_nettype wire

/* File: sim/sss_semaphore_events_properties.sv */
// Purpose: Port-level checks of the semaphore block
// Assumes: Bound to sss_semaphore_events, one clock domain
// Notes: Bind follows the module
`timescale 1ns/1ps
`default_nettype none
`include "sss_consts.svh"

module sss_sem_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Engine side
    input wire logic ENG_ACQ_REQ,
    input wire logic ENG_DONE,
    input wire logic ENG_OWNS,
    input wire logic CPU_OWNS
);
    logic wr_done;
    logic acq_wr;
    logic rel_wr;
    logic is_free;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
    assign acq_wr = wr_done && PADDR == `SSS_OFS_ACQUIRE && PWDATA[0];
    assign rel_wr = wr_done && PADDR == `SSS_OFS_RELEASE && PWDATA[0];
    assign is_free = !ENG_OWNS && !CPU_OWNS;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence access_start;
        PSEL && $rose(PENABLE);
    endsequence
    sequence one_wait;
        !PREADY ##1 PREADY;
    endsequence
    apb_one_wait_a: assert property (access_start |-> one_wait)
        else $error("access did not end after one wait state");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    single_owner_a: assert property (!(ENG_OWNS && CPU_OWNS))
        else $error("two owners at once");
    engine_take_a: assert property (is_free && ENG_ACQ_REQ && !acq_wr |=> ENG_OWNS)
        else $error("engine not granted free semaphore");
    cpu_take_a: assert property (is_free && acq_wr |=> CPU_OWNS)
        else $error("acquire from free not granted");
    cpu_release_a: assert property (CPU_OWNS && rel_wr |=> is_free)
        else $error("release did not free semaphore");
    cpu_hold_a: assert property (CPU_OWNS && !rel_wr |=> CPU_OWNS)
        else $error("processor lost semaphore");
    engine_hold_a: assert property (ENG_OWNS && !ENG_DONE && !rel_wr |=> ENG_OWNS)
        else $error("engine lost semaphore early");
    engine_done_a: assert property (ENG_OWNS && ENG_DONE && !rel_wr |=> !ENG_OWNS)
        else $error("engine kept semaphore after done");
endmodule

bind sss_semaphore_events sss_sem_checker u_chk (.CLK(CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ENG_ACQ_REQ(ENG_ACQ_REQ),
    .ENG_DONE(ENG_DONE), .ENG_OWNS(ENG_OWNS), .CPU_OWNS(CPU_OWNS));
`default_nettype wire

/* File: sim/tb_sss_semaphore_events.sv */
// Purpose: Register-level test of the semaphore block
// Assumes: One wait state APB slave, engine strobes on CLK
// Notes: Bench drives the engine side itself
`timescale 1ns/1ps
`default_nettype none
`include "sss_consts.svh"

module tb_sss_semaphore_events;
    logic CLK = 1'h0, RESET_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic ENG_ACQ_REQ = 1'h0, ENG_DONE = 1'h0, ENG_RX_FULL = 1'h0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h00000000, PRDATA, rd;
    logic PREADY, PSLVERR, ENG_OWNS, CPU_OWNS, IRQ, err;
    int fails = 0, checks_done = 0;
    always #20 CLK = ~CLK;
    sss_semaphore_events dut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ENG_ACQ_REQ(ENG_ACQ_REQ),
        .ENG_DONE(ENG_DONE), .ENG_RX_FULL(ENG_RX_FULL), .ENG_OWNS(ENG_OWNS),
        .CPU_OWNS(CPU_OWNS), .IRQ(IRQ));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'h1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        @(posedge CLK);
        while (PREADY !== 1'h1) begin
            @(posedge CLK);
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0; PENABLE <= 1'h0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h00000000);
        check(what, rd, exp);
    endtask
    task eng(input logic done);
        @(posedge CLK);
        if (done) ENG_DONE <= 1'h1;
        else ENG_RX_FULL <= 1'h1;
        @(posedge CLK);
        ENG_DONE <= 1'h0; ENG_RX_FULL <= 1'h0;
    endtask
    task grab;
        wr(`SSS_OFS_RELEASE, 32'h00000001);
        @(posedge CLK);
        ENG_ACQ_REQ <= 1'h1;
        @(posedge CLK);
        ENG_ACQ_REQ <= 1'h0;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge CLK);
        RESET_N <= 1'h1;
        rchk("rxfull", `SSS_OFS_EV_RXFULL, 32'h00000000);
        rchk("granted", `SSS_OFS_EV_GRANTED, 32'h00000000);
        rchk("short", `SSS_OFS_SHORTCUT, 32'h00000000);
        rchk("en set", `SSS_OFS_IRQ_SET, 32'h00000000);
        rchk("en clr", `SSS_OFS_IRQ_CLR, 32'h00000000);
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000001);
        check("cpu owns", {31'h0, CPU_OWNS}, 32'h00000001);
        check("eng owns", {31'h0, ENG_OWNS}, 32'h00000000);
        apb(1'h0, 12'h0FC, 32'h00000000);
        check("slverr", {31'h0, err}, 32'h00000001);
        $display("test reset done");
        grab();
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000002);
        check("eng owns", {31'h0, ENG_OWNS}, 32'h00000001);
        check("cpu owns", {31'h0, CPU_OWNS}, 32'h00000000);
        eng(1'h0);
        rchk("rxfull", `SSS_OFS_EV_RXFULL, 32'h00000001);
        wr(`SSS_OFS_EV_RXFULL, 32'h00000000);
        rchk("rxfull", `SSS_OFS_EV_RXFULL, 32'h00000000);
        wr(`SSS_OFS_ACQUIRE, 32'h00000001);
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000003);
        rchk("granted", `SSS_OFS_EV_GRANTED, 32'h00000000);
        eng(1'h1);
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000001);
        rchk("done", `SSS_OFS_EV_DONE, 32'h00000001);
        eng(1'h0);
        rchk("rxfull", `SSS_OFS_EV_RXFULL, 32'h00000000);
        wr(`SSS_OFS_SEM_STATUS, 32'h00000000);
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000001);
        rchk("granted", `SSS_OFS_EV_GRANTED, 32'h00000001);
        $display("test handover done");
        wr(`SSS_OFS_SHORTCUT, 32'h00000001);
        rchk("short", `SSS_OFS_SHORTCUT, 32'h00000001);
        grab();
        eng(1'h1);
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000001);
        wr(`SSS_OFS_SHORTCUT, 32'h00000000);
        grab();
        eng(1'h1);
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000000);
        wr(`SSS_OFS_ACQUIRE, 32'h00000001);
        rchk("status", `SSS_OFS_SEM_STATUS, 32'h00000001);
        $display("test shortcut done");
        wr(`SSS_OFS_IRQ_SET, 32'h00000005);
        wr(`SSS_OFS_IRQ_SET, 32'h00000000);
        rchk("en set", `SSS_OFS_IRQ_SET, 32'h00000005);
        wr(`SSS_OFS_IRQ_CLR, 32'h00000001);
        wr(`SSS_OFS_IRQ_CLR, 32'h00000000);
        rchk("en clr", `SSS_OFS_IRQ_CLR, 32'h00000004);
        rchk("pend", `SSS_OFS_IRQ_PEND, 32'h00000007);
        wr(`SSS_OFS_RELEASE, 32'h00000001);
        wr(`SSS_OFS_ACQUIRE, 32'h00000001);
        repeat (2) @(posedge CLK);
        check("irq", {31'h0, IRQ}, 32'h00000001);
        rchk("pend", `SSS_OFS_IRQ_PEND, 32'h00000004);
        repeat (2) @(posedge CLK);
        check("irq", {31'h0, IRQ}, 32'h00000000);
        rchk("pend", `SSS_OFS_IRQ_PEND, 32'h00000000);
        wr(`SSS_OFS_IRQ_CLR, 32'h00000004);
        wr(`SSS_OFS_RELEASE, 32'h00000001);
        wr(`SSS_OFS_ACQUIRE, 32'h00000001);
        repeat (2) @(posedge CLK);
        check("irq", {31'h0, IRQ}, 32'h00000000);
        $display("test interrupt done");
        tally_and_finish();
    end
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
